/* File: logic/tsq_defs.vh */
// Constants for the trigger stamp queue readout block
`ifndef TSQ_DEFS_VH
`define TSQ_DEFS_VH
// ==================================================
// Register indices (word address = 4 x index)
`define TSQ_REG_CMD       16'hB798
`define TSQ_REG_LEVEL     16'hB7A2
`define TSQ_REG_READ      16'hB7C0
// ==================================================
// Command codes
`define TSQ_CMD_CLEAR     32'h0000_0000
`define TSQ_CMD_DISABLE   32'h0000_000A
`define TSQ_CMD_PLAIN     32'h0000_0014
`define TSQ_CMD_CLRSTART  32'h0000_001E
`define TSQ_CMD_REFSEC    32'h0000_0028
// ==================================================
// Queue level codes
`define TSQ_LVL_EMPTY     2'h0
`define TSQ_LVL_BELOW     2'h1
`define TSQ_LVL_ABOVE     2'h2
`define TSQ_LVL_OVERRUN   2'h3
// ==================================================
// Sizes
`define TSQ_DEPTH_LOG2    5
`define TSQ_DEPTH         32
`define TSQ_HALF          16
`define TSQ_STAMP_W       56
`define TSQ_SEC_W         24
`define TSQ_SUB_W         32
`endif

/* File: logic/tsq_stamp_queue.v */
// Stamp counter, capture path and stamp queue with register read port
`timescale 1ns/1ps
`include "tsq_defs.vh"
// What this block does
// RULE1: Each queue read port access returns one 32-bit word from the queue head.
// RULE2: Reading an empty queue returns zero.
// RULE3: Stamps are 56 bits, zero-extended to 64, read as two words.
// RULE4: Counter advances once per sample clock since last clear.
// RULE5: Capture happens when the trigger is recognised internally.
// RULE6: Trigger to capture latency is fixed for given settings.
// RULE7: Plain counting, triggered recording: one stamp per trigger, low word first.
// RULE8: Gated recording captures gate open and gate close, alternating, low first.
// RULE9: Reference-second mode delivers sample count first, then seconds.
// RULE10: Each read removes the returned word; reads walk in capture order.
// RULE11: Level status: 0 empty, 1 below half, 2 above half, 3 full or a capture lost since the queue last emptied.
// RULE12: Counter-clear command sets the whole counter to zero.
// RULE13: Reference mode: upper counts second pulses, lower counts samples, cleared per pulse.
module tsq_stamp_queue (
    input wire clk,
    input wire resetn,
    input wire sample_en,
    input wire trig_event,
    input wire gated_mode,
    input wire gate_level,
    input wire second_pulse,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_index,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg reg_ack
);

// ==================================================
// Mode and counter
// Mode is one-hot so the command read-back needs no encoder
reg [2:0] mode_q;
localparam M_OFF = 3'h1;
localparam M_PLAIN = 3'h2;
localparam M_REF = 3'h4;

// Clear-on-start shares the plain path; the start clear is left to the host
reg [`TSQ_STAMP_W-1:0] cnt_q;
reg gate_q;

wire cmd_wr = reg_wr && (reg_index == `TSQ_REG_CMD);
// Clear leaves the mode alone; host sets the mode, then clears
wire clear_cmd = cmd_wr && (reg_wdata == `TSQ_CMD_CLEAR);

always @(posedge clk) begin
    if (!resetn) begin
        mode_q <= M_OFF;
    end else if (cmd_wr) begin
        if (reg_wdata == `TSQ_CMD_DISABLE) begin
            mode_q <= M_OFF;
        end else if (reg_wdata == `TSQ_CMD_PLAIN || reg_wdata == `TSQ_CMD_CLRSTART) begin
            mode_q <= M_PLAIN;
        end else if (reg_wdata == `TSQ_CMD_REFSEC) begin
            mode_q <= M_REF;
        end
    end
end

// Seconds pulse wins over a sample in the same cycle; that sample is lost
always @(posedge clk) begin
    if (!resetn) begin
        cnt_q <= 56'h0;
    end else if (clear_cmd) begin
        cnt_q <= 56'h0; // RULE12
    end else if (mode_q == M_REF && second_pulse) begin
        // Lower part restarts at each second, upper counts seconds
        cnt_q <= {cnt_q[55:32] + 24'h1, 32'h0}; // RULE13
    end else if (sample_en) begin
        if (mode_q == M_REF) begin
            cnt_q <= {cnt_q[55:32], cnt_q[31:0] + 32'h1}; // RULE13
        end else begin
            cnt_q <= cnt_q + 56'h1; // RULE4
        end
    end
end

// ==================================================
// Capture: fixed one-cycle path from internal event, so latency never varies
// Gate edges only count in gated recording; plain triggers are then ignored
wire gate_edge = gated_mode && (gate_level != gate_q); // RULE8
wire capture = (mode_q != M_OFF) && ((!gated_mode && trig_event) || gate_edge); // RULE5 RULE6 RULE7
always @(posedge clk) begin
    if (!resetn) begin
        gate_q <= 1'b0;
    end else begin
        gate_q <= gate_level;
    end
end

// ==================================================
// Two-entry skid buffer between capture and queue
// Absorbs captures while the queue is full; a third one is counted as lost
reg [55:0] skid_d0_q;
reg [55:0] skid_d1_q;
reg [1:0] skid_n_q;
wire q_ready;
wire skid_valid = (skid_n_q != 2'h0);
wire skid_pop = skid_valid && q_ready;
// Push allowed when full only if the head leaves in the same cycle
wire skid_push = capture && (skid_n_q != 2'h2 || skid_pop);

always @(posedge clk) begin
    if (!resetn) begin
        skid_n_q <= 2'h0;
        skid_d0_q <= 56'h0;
        skid_d1_q <= 56'h0;
    end else begin
        if (skid_pop) begin
            skid_d0_q <= skid_d1_q;
        end
        if (skid_push) begin
            if ((skid_n_q == 2'h0) || (skid_n_q == 2'h1 && skid_pop)) begin
                skid_d0_q <= cnt_q;
            end else begin
                skid_d1_q <= cnt_q;
            end
        end
        skid_n_q <= skid_n_q + {1'b0, skid_push} - {1'b0, skid_pop};
    end
end

// ==================================================
// Stamp queue of 64-bit entries, read as low then high word
// Only 56 bits are stored; the top byte is supplied as zero on read
reg [55:0] mem [0:`TSQ_DEPTH-1];
reg [4:0] wp_q;
reg [4:0] rp_q;
reg [5:0] fill_q;
reg half_q;
reg lost_q;

wire q_full = (fill_q == 6'h20);
wire q_empty = (fill_q == 6'h0);
// Full stops the skid buffer draining; nothing stored is overwritten
assign q_ready = !q_full;

wire rd_port = reg_rd && (reg_index == `TSQ_REG_READ);
// Entry leaves only after its high word, so a stamp is never split
wire q_pop = rd_port && !q_empty && half_q;

always @(posedge clk) begin
    if (skid_pop) begin
        mem[wp_q] <= skid_d0_q;
    end
end

always @(posedge clk) begin
    if (!resetn) begin
        wp_q <= 5'h0;
        rp_q <= 5'h0;
        fill_q <= 6'h0;
        half_q <= 1'b0;
        lost_q <= 1'b0;
    end else begin
        if (skid_pop) begin
            wp_q <= wp_q + 5'h1;
        end
        if (rd_port && !q_empty) begin
            half_q <= !half_q; // RULE3 RULE10
        end
        if (q_pop) begin
            rp_q <= rp_q + 5'h1; // RULE10
        end
        // Push and pop in one cycle leave the fill unchanged
        fill_q <= fill_q + {5'h0, skid_pop} - {5'h0, q_pop};
        if (capture && !skid_push) begin
            lost_q <= 1'b1;
        end else if (q_empty && !skid_valid) begin
            lost_q <= 1'b0;
        end
    end
end

// ==================================================
// Register read answers, one cycle after the strobe
// Read data holds between reads so a slow host may sample it late
// Head word chosen by half_q: low first, then high
wire [63:0] head = {8'h0, mem[rp_q]}; // RULE3

always @(posedge clk) begin
    if (!resetn) begin
        reg_rdata <= 32'h0;
        reg_ack <= 1'b0;
    end else begin
        // Every strobe is answered, mapped or not
        reg_ack <= reg_rd || reg_wr;
        if (rd_port) begin
            if (q_empty) begin
                reg_rdata <= 32'h0; // RULE2
            end else if (half_q) begin
                reg_rdata <= head[63:32]; // RULE1 RULE9
            end else begin
                reg_rdata <= head[31:0]; // RULE1 RULE7 RULE9
            end
        // Level read does not disturb the queue
        end else if (reg_rd && reg_index == `TSQ_REG_LEVEL) begin
            if (q_empty) begin
                reg_rdata <= {30'h0, `TSQ_LVL_EMPTY}; // RULE11
            end else if (q_full || lost_q) begin
                reg_rdata <= {30'h0, `TSQ_LVL_OVERRUN}; // RULE11
            end else if (fill_q > 6'h10) begin
                reg_rdata <= {30'h0, `TSQ_LVL_ABOVE}; // RULE11
            end else begin
                reg_rdata <= {30'h0, `TSQ_LVL_BELOW}; // RULE11
            end
        end else if (reg_rd && reg_index == `TSQ_REG_CMD) begin
            reg_rdata <= {29'h0, mode_q};
        // Unmapped indices read as zero
        end else if (reg_rd) begin
            reg_rdata <= 32'h0;
        end
    end
end

endmodule

/* File: test/tsq_checker.sv */
// Assertions on the stamp queue register port
`timescale 1ns/1ps
`include "tsq_defs.vh"
module tsq_checker (
    input wire clk, input wire resetn, input wire sample_en, input wire trig_event,
    input wire gated_mode, input wire gate_level, input wire second_pulse,
    input wire reg_wr, input wire reg_rd, input wire [15:0] reg_index,
    input wire [31:0] reg_wdata, input wire [31:0] reg_rdata, input wire reg_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire stb = reg_rd | reg_wr;
    wire lvl = reg_index == `TSQ_REG_LEVEL;
    wire cmd = reg_index == `TSQ_REG_CMD;
    wire mapped = cmd || lvl || reg_index == `TSQ_REG_READ;
    // ==========
    // Port handshake
    a_ack_follows: assert property (stb |=> reg_ack) else $error("no ack");
    a_ack_cause: assert property (reg_ack |-> $past(stb)) else $error("stray ack");
    a_ack_single: assert property (stb ##1 !stb |=> !reg_ack) else $error("long ack");
    a_reset_quiet: assert property ($rose(resetn) |-> !reg_ack) else $error("ack at reset");
    a_rdata_hold: assert property (!reg_ack |-> $stable(reg_rdata)) else $error("rdata moved");
    // ==========
    // Read values
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
        else $error("unmapped nonzero");
    a_level_width: assert property (reg_rd && lvl |=> reg_rdata[31:2] == 30'h0)
        else $error("level wide");
    a_mode_onehot: assert property (reg_rd && cmd |=> $onehot(reg_rdata[2:0]))
        else $error("mode code");
    c_queue_read: cover property (reg_rd && reg_index == `TSQ_REG_READ);
    c_gate_edge: cover property (gated_mode && $changed(gate_level));
    c_second: cover property (second_pulse);
endmodule

/* File: test/tsq_host.sv */
// Host model issuing register accesses
`timescale 1ns/1ps
module tsq_host (
    input wire clk, input wire [31:0] reg_rdata, input wire reg_ack,
    output reg reg_wr, output reg reg_rd, output reg [15:0] reg_index, output reg [31:0] reg_wdata
);
    initial begin
        {reg_wr, reg_rd, reg_index, reg_wdata} = 50'h0;
    end
    // Strobe held one edge; answer taken while it stands
    task acc(input w, input [15:0] i, input [31:0] d, output [31:0] q);
        begin
            @(negedge clk);
            {reg_wr, reg_rd, reg_index, reg_wdata} = {w, !w, i, d};
            @(negedge clk);
            q = reg_rdata;
            {reg_wr, reg_rd} = 2'h0;
        end
    endtask
endmodule

/* File: test/tsq_stamp_queue_tb_top.sv */
// Directed bench for the stamp queue
`timescale 1ns/1ps
`include "tsq_defs.vh"
module tsq_stamp_queue_tb_top;
    reg clk = 1'b0, resetn = 1'b0, sample_en = 1'b0, trig_event = 1'b0;
    reg gated_mode = 1'b0, gate_level = 1'b0, second_pulse = 1'b0;
    wire reg_wr, reg_rd, reg_ack;
    wire [15:0] reg_index;
    wire [31:0] reg_wdata, reg_rdata;
    integer mismatches = 0, total_checks = 0;
    reg [31:0] q;
    always #50 clk = ~clk;
    tsq_stamp_queue dut (
        .clk(clk), .resetn(resetn), .sample_en(sample_en), .trig_event(trig_event),
        .gated_mode(gated_mode), .gate_level(gate_level), .second_pulse(second_pulse),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack)
    );
    tsq_host host (
        .clk(clk), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata)
    );
    task rd(input [15:0] i, input [31:0] e);
        begin
            host.acc(1'b0, i, 32'h0, q);
            total_checks++;
            if (q !== e || reg_ack !== 1'b1) begin
                mismatches++;
                $display("mismatch reg %h expected %h seen %h ack %b", i, e, q, reg_ack);
            end
        end
    endtask
    task wr(input [31:0] d);
        host.acc(1'b1, `TSQ_REG_CMD, d, q);
    endtask
    task samp(input integer n);
        repeat (n) begin
            @(negedge clk) sample_en = 1'b1;
            @(negedge clk) sample_en = 1'b0;
        end
    endtask
    // Capture is readable two edges after the trigger edge; three more cycles are waited
    task trig;
        begin
            @(negedge clk) trig_event = 1'b1;
            @(negedge clk) trig_event = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
    task gate(input v);
        begin
            @(negedge clk) gate_level = v;
            repeat (3) @(negedge clk);
        end
    endtask
    // ==========
    // Scenarios
    task t_empty;
        begin
            rd(`TSQ_REG_READ, 32'h0);
            rd(`TSQ_REG_LEVEL, `TSQ_LVL_EMPTY);
            rd(16'h0000, 32'h0);
            $display("empty done");
        end
    endtask
    task t_plain;
        begin
            wr(`TSQ_CMD_PLAIN);
            samp(2);
            wr(`TSQ_CMD_CLEAR);
            samp(5);
            trig;
            samp(3);
            trig;
            rd(`TSQ_REG_CMD, 32'h2);
            rd(`TSQ_REG_LEVEL, `TSQ_LVL_BELOW);
            rd(`TSQ_REG_READ, 32'h5);
            rd(`TSQ_REG_READ, 32'h0);
            rd(`TSQ_REG_READ, 32'h8);
            rd(`TSQ_REG_READ, 32'h0);
            rd(`TSQ_REG_READ, 32'h0);
            $display("plain done");
        end
    endtask
    task t_gated;
        begin
            gated_mode = 1'b1;
            wr(`TSQ_CMD_CLEAR);
            samp(4);
            gate(1'b1);
            samp(2);
            gate(1'b0);
            rd(`TSQ_REG_READ, 32'h4);
            rd(`TSQ_REG_READ, 32'h0);
            rd(`TSQ_REG_READ, 32'h6);
            rd(`TSQ_REG_READ, 32'h0);
            gated_mode = 1'b0;
            $display("gated done");
        end
    endtask
    task t_ref;
        begin
            wr(`TSQ_CMD_REFSEC);
            wr(`TSQ_CMD_CLEAR);
            samp(3);
            @(negedge clk) second_pulse = 1'b1;
            @(negedge clk) second_pulse = 1'b0;
            samp(2);
            trig;
            rd(`TSQ_REG_CMD, 32'h4);
            rd(`TSQ_REG_READ, 32'h2);
            rd(`TSQ_REG_READ, 32'h1);
            $display("refsec done");
        end
    endtask
    task t_level;
        begin
            wr(`TSQ_CMD_DISABLE);
            trig;
            rd(`TSQ_REG_CMD, 32'h1);
            rd(`TSQ_REG_LEVEL, {30'h0, `TSQ_LVL_EMPTY});
            wr(`TSQ_CMD_CLRSTART);
            wr(`TSQ_CMD_CLEAR);
            rd(`TSQ_REG_CMD, 32'h2);
            repeat (17) trig;
            rd(`TSQ_REG_LEVEL, {30'h0, `TSQ_LVL_ABOVE});
            repeat (18) trig;
            rd(`TSQ_REG_LEVEL, {30'h0, `TSQ_LVL_OVERRUN});
            repeat (68) rd(`TSQ_REG_READ, 32'h0);
            rd(`TSQ_REG_LEVEL, {30'h0, `TSQ_LVL_EMPTY});
            $display("level done");
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        t_empty;
        t_plain;
        t_gated;
        t_ref;
        t_level;
        report_and_stop;
    end
    initial begin
        #1000000;
        mismatches++;
        report_and_stop;
    end
endmodule
bind tsq_stamp_queue tsq_checker chk_i (
    .clk(clk), .resetn(resetn), .sample_en(sample_en), .trig_event(trig_event),
    .gated_mode(gated_mode), .gate_level(gate_level), .second_pulse(second_pulse),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack)
);
